// [logic/bfs_defs.svh]
// Constants of the bit, flag and shift datapath: bus map, fields, opcodes, flag positions.
// Included by every design file that needs a figure; holds definitions only.
`ifndef BFS_DEFS_SVH
`define BFS_DEFS_SVH

// Wishbone byte addresses and address windows
`define BFS_ADR_OPND 10'h000
`define BFS_ADR_CMD 10'h004
`define BFS_ADR_STATUS 10'h008
`define BFS_WIN_CTRL 2'h0
`define BFS_WIN_GPR 2'h1
`define BFS_WIN_IO 2'h2

// Operand register fields
`define BFS_OPND_REG 4:0
`define BFS_OPND_BIT 10:8
`define BFS_OPND_IO 21:16

// Command register fields
`define BFS_CMD_OPCODE 5:0
`define BFS_CMD_BUSY 0
`define BFS_CMD_OP 13:8

// Opcodes
`define BFS_OP_NOP 6'h00
`define BFS_OP_SET_IO_BIT 6'h01
`define BFS_OP_CLEAR_IO_BIT 6'h02
`define BFS_OP_SHL 6'h03
`define BFS_OP_SHR 6'h04
`define BFS_OP_ROL 6'h05
`define BFS_OP_ROR 6'h06
`define BFS_OP_SWAP 6'h07
`define BFS_OP_FLAG_SET_IDX 6'h08
`define BFS_OP_FLAG_CLR_IDX 6'h09
`define BFS_OP_BIT_TO_T 6'h0A
`define BFS_OP_T_TO_BIT 6'h0B
`define BFS_OP_SLEEP 6'h0C
`define BFS_OP_WDR 6'h0D
`define BFS_OP_BREAK 6'h0E
// Dedicated flag opcodes: class in [5:3], flag position in [2:0]
`define BFS_OP_CLASS 5:3
`define BFS_OP_FLAGSEL 2:0
`define BFS_OP_DED_SET 3'h2
`define BFS_OP_DED_CLR 3'h3

// Status register bit positions
`define BFS_FLAG_C 3'h0
`define BFS_FLAG_Z 3'h1
`define BFS_FLAG_N 3'h2
`define BFS_FLAG_V 3'h3
`define BFS_FLAG_S 3'h4
`define BFS_FLAG_H 3'h5
`define BFS_FLAG_T 3'h6
`define BFS_FLAG_I 3'h7

// Reset values and masks
`define BFS_STATUS_RST 8'h00
`define BFS_MEM_RST 8'h00
`define BFS_BIT0 8'h01

`endif

// [logic/bfs_pkg.sv]
// Types shared by the bit, flag and shift datapath files.
// Assumes the constants header is included by the files that need figures.
package bfs_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_EXEC1 = 3'b010,
    ST_EXEC2 = 3'b100
  } bfs_state_type;

  typedef enum logic [2:0]
  {
    SH_LSL = 3'h0,
    SH_LSR = 3'h1,
    SH_ROL = 3'h2,
    SH_ROR = 3'h3,
    SH_SWAP = 3'h4
  } bfs_shift_type;

endpackage

// [logic/bfs_shift_unit.sv]
// Combinational shift, rotate-through-carry and nibble-swap unit with its flag results.
// Assumes the caller decides whether the flag outputs are stored.
`timescale 1ns/1ps
`include "bfs_defs.svh"

module bfs_shift_unit
  import bfs_pkg::*;
(
  input wire bfs_shift_type shiftOp, // Operation to perform
  input wire logic [7:0] dataIn, // Register value before the operation
  input wire logic carryIn, // Carry flag before the operation
  output logic [7:0] dataOut, // Register value after the operation
  output logic carryOut, // New carry
  output logic zeroOut, // New zero flag
  output logic negOut, // New negative flag
  output logic ovfOut // New overflow flag, negative xor carry
);

  always_comb
  begin
    dataOut = dataIn;
    carryOut = carryIn;
    unique case (shiftOp)
      SH_LSL:
      begin
        dataOut = {dataIn[6:0], 1'b0};
        carryOut = dataIn[7];
      end
      SH_LSR:
      begin
        dataOut = {1'b0, dataIn[7:1]};
        carryOut = dataIn[0];
      end
      SH_ROL:
      begin
        dataOut = {dataIn[6:0], carryIn};
        carryOut = dataIn[7];
      end
      SH_ROR:
      begin
        dataOut = {carryIn, dataIn[7:1]};
        carryOut = dataIn[0];
      end
      SH_SWAP:
      begin
        dataOut = {dataIn[3:0], dataIn[7:4]};
      end
      default:
      begin
        dataOut = dataIn;
      end
    endcase
  end

  assign zeroOut = (dataOut == `BFS_MEM_RST);
  assign negOut = dataOut[7];
  assign ovfOut = dataOut[7] ^ carryOut;

endmodule // bfs_shift_unit

// [logic/bfs_bit_flag_core.sv]
// Bit-manipulation, shift/rotate, status-flag and core-control executor with its
// general register file, I/O register file and status register.
// Assumes a classic Wishbone master on sys_clk; sleep, watchdog and debug logic sit outside.
`timescale 1ns/1ps
`include "bfs_defs.svh"

module bfs_bit_flag_core
  import bfs_pkg::*;
(
  input wire logic sys_clk, // Core clock, 50 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [9:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic debugEnable, // On-chip debugging in use
  output logic sleepReq, // One-cycle request to the power-saving logic
  output logic watchdogRestart, // One-cycle watchdog restart
  output logic breakReq, // One-cycle debug break request
  output logic [7:0] statusFlags, // Status register contents
  output logic busy // Instruction in progress
);

  logic [7:0] gprMem [0:31];
  logic [7:0] ioMem [0:63];
  logic [31:0] operand_ff;
  bfs_state_type state_ff;
  logic [5:0] cmdOp_ff;
  logic [4:0] cmdReg_ff;
  logic [2:0] cmdBit_ff;
  logic [5:0] cmdIo_ff;
  logic [7:0] ioTmp_ff;
  logic [7:0] status_ff;
  logic [31:0] wbDat_ff;
  logic wbAck_ff;
  logic sleep_ff;
  logic wdt_ff;
  logic brk_ff;
  logic busy_ff;

  logic busReq;
  logic busWr;
  logic isCtrl;
  logic isGpr;
  logic isIo;
  logic cmdStart;
  logic gprBusWe;
  logic ioBusWe;
  logic statusBusWe;
  logic [31:0] rdData;
  logic [7:0] curReg;
  logic [7:0] curIo;
  logic [7:0] bitMask;
  logic inExec1;
  bfs_shift_type shiftSel;
  logic shiftFlags;
  logic shiftUse;
  logic [7:0] shiftData;
  logic shiftC;
  logic shiftZ;
  logic shiftN;
  logic shiftV;
  logic execGprWe;
  logic [7:0] execGprData;
  logic ioExecWe;
  logic [7:0] ioExecData;

  // Bus decode; writes take effect on the edge where the master samples ack
  assign busReq = wb_cyc_i & wb_stb_i;
  assign busWr = busReq & wb_we_i & wbAck_ff;
  assign isCtrl = (wb_adr_i[9:8] == `BFS_WIN_CTRL);
  assign isGpr = (wb_adr_i[9:8] == `BFS_WIN_GPR) & ~wb_adr_i[7];
  assign isIo = (wb_adr_i[9:8] == `BFS_WIN_IO);
  // Storage writes are dropped while an instruction runs so it sees stable operands
  assign cmdStart = busWr & wb_sel_i[0] & (wb_adr_i == `BFS_ADR_CMD) & (state_ff == ST_IDLE);
  assign gprBusWe = busWr & wb_sel_i[0] & isGpr & (state_ff == ST_IDLE);
  assign ioBusWe = busWr & wb_sel_i[0] & isIo & (state_ff == ST_IDLE);
  assign statusBusWe = busWr & wb_sel_i[0] & (wb_adr_i == `BFS_ADR_STATUS)
                       & (state_ff == ST_IDLE);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wbAck_ff <= 1'b0;
      wbDat_ff <= 32'h0000_0000;
    end
    else
    begin
      wbAck_ff <= busReq & ~wbAck_ff;
      if (busReq & ~wbAck_ff)
        wbDat_ff <= rdData;
    end
  end

  always_comb
  begin
    rdData = 32'h0000_0000;
    if (isCtrl)
    begin
      if (wb_adr_i == `BFS_ADR_OPND)
        rdData = operand_ff;
      else if (wb_adr_i == `BFS_ADR_CMD)
      begin
        rdData[`BFS_CMD_OP] = cmdOp_ff;
        rdData[`BFS_CMD_BUSY] = busy_ff;
      end
      else if (wb_adr_i == `BFS_ADR_STATUS)
        rdData[7:0] = status_ff;
    end
    else if (isGpr)
      rdData[7:0] = gprMem[wb_adr_i[6:2]];
    else if (isIo)
      rdData[7:0] = ioMem[wb_adr_i[7:2]];
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gOpndLane
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
          operand_ff[8*g +: 8] <= 8'h00;
        else if (busWr & wb_sel_i[g] & (wb_adr_i == `BFS_ADR_OPND))
          operand_ff[8*g +: 8] <= wb_dat_i[8*g +: 8];
      end
    end
  endgenerate

  // Operands are frozen at issue so a later operand write cannot disturb a running op
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cmdOp_ff <= `BFS_OP_NOP;
      cmdReg_ff <= 5'h00;
      cmdBit_ff <= 3'h0;
      cmdIo_ff <= 6'h00;
    end
    else if (cmdStart)
    begin
      cmdOp_ff <= wb_dat_i[`BFS_CMD_OPCODE];
      cmdReg_ff <= operand_ff[`BFS_OPND_REG];
      cmdBit_ff <= operand_ff[`BFS_OPND_BIT];
      cmdIo_ff <= operand_ff[`BFS_OPND_IO];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_IDLE;
      busy_ff <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          if (cmdStart)
          begin
            state_ff <= ST_EXEC1;
            busy_ff <= 1'b1;
          end
        end
        ST_EXEC1:
        begin
          if ((cmdOp_ff == `BFS_OP_SET_IO_BIT) || (cmdOp_ff == `BFS_OP_CLEAR_IO_BIT))
            state_ff <= ST_EXEC2;
          else
          begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
          end
        end
        ST_EXEC2:
        begin
          state_ff <= ST_IDLE;
          busy_ff <= 1'b0;
        end
        default:
        begin
          state_ff <= ST_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  assign inExec1 = (state_ff == ST_EXEC1);
  assign curReg = gprMem[cmdReg_ff];
  assign curIo = ioMem[cmdIo_ff];
  assign bitMask = `BFS_BIT0 << cmdBit_ff;

  always_comb
  begin
    shiftSel = SH_LSL;
    shiftUse = 1'b0;
    shiftFlags = 1'b1;
    case (cmdOp_ff)
      `BFS_OP_SHL: shiftUse = 1'b1;
      `BFS_OP_SHR:
      begin
        shiftSel = SH_LSR;
        shiftUse = 1'b1;
      end
      `BFS_OP_ROL:
      begin
        shiftSel = SH_ROL;
        shiftUse = 1'b1;
      end
      `BFS_OP_ROR:
      begin
        shiftSel = SH_ROR;
        shiftUse = 1'b1;
      end
      `BFS_OP_SWAP:
      begin
        shiftSel = SH_SWAP;
        shiftUse = 1'b1;
        shiftFlags = 1'b0;
      end
      default: shiftFlags = 1'b0;
    endcase
  end

  bfs_shift_unit uShift
  (
    .shiftOp(shiftSel),
    .dataIn(curReg),
    .carryIn(status_ff[`BFS_FLAG_C]),
    .dataOut(shiftData),
    .carryOut(shiftC),
    .zeroOut(shiftZ),
    .negOut(shiftN),
    .ovfOut(shiftV)
  );

  always_comb
  begin
    execGprWe = 1'b0;
    execGprData = curReg;
    if (inExec1 && shiftUse)
    begin
      execGprWe = 1'b1;
      execGprData = shiftData;
    end
    else if (inExec1 && (cmdOp_ff == `BFS_OP_T_TO_BIT))
    begin
      execGprWe = 1'b1;
      execGprData[cmdBit_ff] = status_ff[`BFS_FLAG_T];
    end
  end

  // Read in the first cycle, written back in the second: a plain read-modify-write
  assign ioExecWe = (state_ff == ST_EXEC2);
  assign ioExecData = (cmdOp_ff == `BFS_OP_SET_IO_BIT) ? (ioTmp_ff | bitMask)
                      : (ioTmp_ff & ~bitMask);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      ioTmp_ff <= `BFS_MEM_RST;
    else if (inExec1)
      ioTmp_ff <= curIo;
  end

  generate
    for (g = 0; g < 32; g = g + 1)
    begin : gGpr
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
          gprMem[g] <= `BFS_MEM_RST;
        else if (gprBusWe && (wb_adr_i[6:2] == 5'(g)))
          gprMem[g] <= wb_dat_i[7:0];
        else if (execGprWe && (cmdReg_ff == 5'(g)))
          gprMem[g] <= execGprData;
      end
    end
    for (g = 0; g < 64; g = g + 1)
    begin : gIo
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
          ioMem[g] <= `BFS_MEM_RST;
        else if (ioBusWe && (wb_adr_i[7:2] == 6'(g)))
          ioMem[g] <= wb_dat_i[7:0];
        else if (ioExecWe && (cmdIo_ff == 6'(g)))
          ioMem[g] <= ioExecData;
      end
    end
  endgenerate

  // Only the bits an instruction names are written; all others hold
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      status_ff <= `BFS_STATUS_RST;
    else if (statusBusWe)
      status_ff <= wb_dat_i[7:0];
    else if (inExec1)
    begin
      if (shiftFlags)
      begin
        status_ff[`BFS_FLAG_C] <= shiftC;
        status_ff[`BFS_FLAG_Z] <= shiftZ;
        status_ff[`BFS_FLAG_N] <= shiftN;
        status_ff[`BFS_FLAG_V] <= shiftV;
      end
      if (cmdOp_ff == `BFS_OP_FLAG_SET_IDX)
        status_ff[cmdBit_ff] <= 1'b1;
      if (cmdOp_ff == `BFS_OP_FLAG_CLR_IDX)
        status_ff[cmdBit_ff] <= 1'b0;
      if (cmdOp_ff == `BFS_OP_BIT_TO_T)
        status_ff[`BFS_FLAG_T] <= curReg[cmdBit_ff];
      if (cmdOp_ff[`BFS_OP_CLASS] == `BFS_OP_DED_SET)
        status_ff[cmdOp_ff[`BFS_OP_FLAGSEL]] <= 1'b1;
      if (cmdOp_ff[`BFS_OP_CLASS] == `BFS_OP_DED_CLR)
        status_ff[cmdOp_ff[`BFS_OP_FLAGSEL]] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sleep_ff <= 1'b0;
      wdt_ff <= 1'b0;
      brk_ff <= 1'b0;
    end
    else
    begin
      sleep_ff <= inExec1 && (cmdOp_ff == `BFS_OP_SLEEP);
      wdt_ff <= inExec1 && (cmdOp_ff == `BFS_OP_WDR);
      // Without a debugger attached the break falls through as a no-operation
      brk_ff <= inExec1 && (cmdOp_ff == `BFS_OP_BREAK) && debugEnable;
    end
  end

  assign wb_dat_o = wbDat_ff;
  assign wb_ack_o = wbAck_ff;
  assign sleepReq = sleep_ff;
  assign watchdogRestart = wdt_ff;
  assign breakReq = brk_ff;
  assign statusFlags = status_ff;
  assign busy = busy_ff;

  logic curMsb;
  logic curLsb;
  logic carryNow;
  assign curMsb = curReg[7];
  assign curLsb = curReg[0];
  assign carryNow = status_ff[`BFS_FLAG_C];

  default clocking cbMain @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_issue(logic [5:0] op);
    (state_ff == ST_EXEC1) && (cmdOp_ff == op);
  endsequence
  sequence s_ioPair(logic [5:0] op);
    s_issue(op) ##1 (state_ff == ST_EXEC2);
  endsequence

  property p_setIo;
    s_ioPair(`BFS_OP_SET_IO_BIT) |=> ((curIo & bitMask) != 8'h00)
      && ((curIo | bitMask) == ($past(curIo, 2) | bitMask))
      && (status_ff == $past(status_ff, 2)) && (state_ff == ST_IDLE);
  endproperty
  a_setIo: assert property (p_setIo) else $error("set-io-bit result wrong");

  property p_clrIo;
    s_ioPair(`BFS_OP_CLEAR_IO_BIT) |=> ((curIo & bitMask) == 8'h00)
      && ((curIo | bitMask) == ($past(curIo, 2) | bitMask))
      && (status_ff == $past(status_ff, 2)) && (state_ff == ST_IDLE);
  endproperty
  a_clrIo: assert property (p_clrIo) else $error("clear-io-bit result wrong");

  property p_shl;
    s_issue(`BFS_OP_SHL) |=> (curReg == ($past(curReg) << 1)) && (carryNow == $past(curMsb))
      && (status_ff[`BFS_FLAG_V] == (curMsb ^ carryNow)) && (state_ff == ST_IDLE);
  endproperty
  a_shl: assert property (p_shl) else $error("shift left wrong");

  property p_shr;
    s_issue(`BFS_OP_SHR) |=> (curReg == ($past(curReg) >> 1)) && (carryNow == $past(curLsb))
      && !status_ff[`BFS_FLAG_N] && (status_ff[`BFS_FLAG_Z] == (curReg == 8'h00));
  endproperty
  a_shr: assert property (p_shr) else $error("shift right wrong");

  property p_rol;
    s_issue(`BFS_OP_ROL) |=> (curReg == (($past(curReg) << 1) | {7'h00, $past(carryNow)}))
      && (carryNow == $past(curMsb));
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong");

  property p_ror;
    s_issue(`BFS_OP_ROR) |=> (curReg == (($past(curReg) >> 1) | {$past(carryNow), 7'h00}))
      && (carryNow == $past(curLsb));
  endproperty
  a_ror: assert property (p_ror) else $error("rotate right wrong");

  property p_swap;
    s_issue(`BFS_OP_SWAP) |=> (curReg == {$past(curReg[3:0]), $past(curReg[7:4])})
      && (status_ff == $past(status_ff));
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");

  property p_flagIdx;
    s_issue(`BFS_OP_FLAG_CLR_IDX) |=> ((status_ff & bitMask) == 8'h00)
      && ((status_ff | bitMask) == ($past(status_ff) | bitMask));
  endproperty
  a_flagIdx: assert property (p_flagIdx) else $error("indexed flag clear wrong");

  property p_bst;
    s_issue(`BFS_OP_BIT_TO_T) ##0 (curReg[cmdBit_ff] == 1'b1) |=> status_ff[`BFS_FLAG_T]
      && (status_ff[5:0] == $past(status_ff[5:0]));
  endproperty
  a_bst: assert property (p_bst) else $error("bit store wrong");

  property p_bld;
    s_issue(`BFS_OP_T_TO_BIT) |=> (curReg[cmdBit_ff] == status_ff[`BFS_FLAG_T])
      && ((curReg | bitMask) == ($past(curReg) | bitMask)) && (status_ff == $past(status_ff));
  endproperty
  a_bld: assert property (p_bld) else $error("bit load wrong");

  property p_dedSet;
    inExec1 && (cmdOp_ff[`BFS_OP_CLASS] == `BFS_OP_DED_SET)
      |=> status_ff[cmdOp_ff[`BFS_OP_FLAGSEL]] && (busy_ff == 1'b0);
  endproperty
  a_dedSet: assert property (p_dedSet) else $error("dedicated flag set wrong");

  property p_sleep;
    s_issue(`BFS_OP_SLEEP) |=> sleepReq && (status_ff == $past(status_ff)) ##1 !sleepReq;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep request wrong");

  property p_wdr;
    s_issue(`BFS_OP_WDR) |=> watchdogRestart && !busy_ff && (status_ff == $past(status_ff));
  endproperty
  a_wdr: assert property (p_wdr) else $error("watchdog restart wrong");

  property p_brk;
    s_issue(`BFS_OP_BREAK) |=> (breakReq == $past(debugEnable)) && (status_ff == $past(status_ff));
  endproperty
  a_brk: assert property (p_brk) else $error("break wrong");

  property p_nop;
    s_issue(`BFS_OP_NOP) |=> (status_ff == $past(status_ff)) && (curReg == $past(curReg))
      && (state_ff == ST_IDLE);
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed state");

endmodule // bfs_bit_flag_core

// [bench/bfs_bit_flag_core_tb.sv]
// Self-checking bench for the bit, flag and shift executor, driven over classic Wishbone.
// Assumes bfs_defs.svh on the include path; sleep, watchdog and debug logic are absent.
`timescale 1ns/1ps
`include "bfs_defs.svh"
`define TB_CHK(nm, ex, got) \
  begin \
    nCompared++; \
    if ((got) !== (ex)) \
    begin \
      badCount++; \
      $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
    end \
  end

module bfs_bit_flag_core_tb
  import bfs_pkg::*;
;
  logic sys_clk;
  logic sys_rst;
  logic wbCyc;
  logic wbStb;
  logic wbWe;
  logic [9:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW;
  logic [31:0] wbDatR;
  logic wbAck;
  logic debugEnable;
  logic sleepReq;
  logic watchdogRestart;
  logic breakReq;
  logic [7:0] statusFlags;
  logic busy;
  logic [31:0] rd;
  logic [8:0] ex;
  logic [7:0] pre;
  logic [7:0] expS;
  logic [7:0] m;
  logic [5:0] ops[5];
  logic [7:0] dv[3];
  logic [5:0] fo[4];
  int badCount;
  int nCompared;
  int nSleep;
  int nWdr;
  int nBrk;

  bfs_bit_flag_core u_bfs_bit_flag_core (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .debugEnable(debugEnable), .sleepReq(sleepReq),
    .watchdogRestart(watchdogRestart), .breakReq(breakReq), .statusFlags(statusFlags),
    .busy(busy)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Pulse counters: a pulse wider than one cycle shows up as an extra count
  always @(posedge sys_clk)
  begin
    if (sleepReq === 1'b1) nSleep++;
    if (watchdogRestart === 1'b1) nWdr++;
    if (breakReq === 1'b1) nBrk++;
  end

  task automatic wbXfer(input logic we, input logic [9:0] adr, input logic [31:0] dat);
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'hF;
    wbAdr <= adr;
    wbDatW <= dat;
    do @(posedge sys_clk); while (wbAck !== 1'b1);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  // Counts the cycles busy is seen high after the command lands
  task automatic exec(input logic [5:0] op, input int expCyc);
    int n;
    wbXfer(1'b1, `BFS_ADR_CMD, {26'h0, op});
    n = 0;
    @(posedge sys_clk);
    while (busy === 1'b1 && n < 50)
    begin
      n++;
      @(posedge sys_clk);
    end
    `TB_CHK("busy cycles", expCyc, n)
  endtask

  function automatic logic [9:0] gA(input int i);
    return 10'h100 + 10'(4 * i);
  endfunction

  function automatic logic [31:0] opnd(input int r, input int b, input int io);
    return {10'h0, 6'(io), 5'h0, 3'(b), 3'h0, 5'(r)};
  endfunction

  // Returns {carry out, result}
  function automatic logic [8:0] shRef(input logic [5:0] op, input logic [7:0] d, input logic c);
    case (op)
      `BFS_OP_SHL: return {d[7], d[6:0], 1'b0};
      `BFS_OP_SHR: return {d[0], 1'b0, d[7:1]};
      `BFS_OP_ROL: return {d[7], d[6:0], c};
      `BFS_OP_ROR: return {d[0], c, d[7:1]};
      default: return {c, d[3:0], d[7:4]};
    endcase
  endfunction

  task automatic wrapUp;
    $display("Compared %0d, mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    wrapUp;
  end

  initial
  begin
    sys_rst = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 10'h000;
    wbSel = 4'hF;
    wbDatW = 32'h0000_0000;
    debugEnable = 1'b0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wbXfer(1'b0, `BFS_ADR_STATUS, 32'h0);
    `TB_CHK("status after reset", 32'h0, rd)
    wbXfer(1'b0, 10'h300, 32'h0);
    `TB_CHK("unmapped read", 32'h0, rd)
    $display("TEST reset done");

    ops = '{`BFS_OP_SHL, `BFS_OP_SHR, `BFS_OP_ROL, `BFS_OP_ROR, `BFS_OP_SWAP};
    dv = '{8'h81, 8'h80, 8'h01};
    foreach (ops[i])
      foreach (dv[j])
        for (int c = 0; c < 2; c++)
        begin
          pre = 8'hF0 | 8'(c);
          wbXfer(1'b1, `BFS_ADR_STATUS, {24'h0, pre});
          wbXfer(1'b1, gA(j + 2), {24'h0, dv[j]});
          wbXfer(1'b1, `BFS_ADR_OPND, opnd(j + 2, 0, 0));
          exec(ops[i], 1);
          ex = shRef(ops[i], dv[j], 1'(c));
          if (ops[i] == `BFS_OP_SWAP)
            expS = pre;
          else
            expS = {pre[7:4], ex[8] ^ ex[7], ex[7], ex[7:0] == 8'h00, ex[8]};
          wbXfer(1'b0, gA(j + 2), 32'h0);
          `TB_CHK("shift result", {24'h0, ex[7:0]}, rd)
          `TB_CHK("shift flags", expS, statusFlags)
        end
    $display("TEST shifts done");

    wbXfer(1'b1, `BFS_ADR_STATUS, 32'h5A);
    wbXfer(1'b1, 10'h2FC, 32'hA5);
    wbXfer(1'b1, `BFS_ADR_OPND, opnd(0, 6, 63));
    exec(`BFS_OP_SET_IO_BIT, 2);
    wbXfer(1'b0, 10'h2FC, 32'h0);
    `TB_CHK("io set", 32'hE5, rd)
    wbXfer(1'b1, `BFS_ADR_OPND, opnd(0, 7, 63));
    exec(`BFS_OP_CLEAR_IO_BIT, 2);
    wbXfer(1'b0, 10'h2FC, 32'h0);
    `TB_CHK("io clear", 32'h65, rd)
    `TB_CHK("io flags", 8'h5A, statusFlags)
    wbXfer(1'b1, 10'h300, 32'hFF);
    `TB_CHK("unmapped write", 8'h5A, statusFlags)
    $display("TEST io bits done");

    for (int s = 0; s < 8; s++)
      for (int b = 0; b < 2; b++)
      begin
        m = 8'h01 << s;
        pre = b ? 8'hFF : 8'h00;
        fo = '{6'h10 + 6'(s), `BFS_OP_FLAG_CLR_IDX, `BFS_OP_FLAG_SET_IDX, 6'h18 + 6'(s)};
        wbXfer(1'b1, `BFS_ADR_STATUS, {24'h0, pre});
        wbXfer(1'b1, `BFS_ADR_OPND, opnd(0, s, 0));
        foreach (fo[k])
        begin
          exec(fo[k], 1);
          expS = (k % 2 == 0) ? (pre | m) : (pre & ~m);
          `TB_CHK("flag op", expS, statusFlags)
        end
      end
    $display("TEST flags done");

    wbXfer(1'b1, `BFS_ADR_STATUS, 32'h0);
    wbXfer(1'b1, gA(9), 32'h40);
    wbXfer(1'b1, `BFS_ADR_OPND, opnd(9, 6, 0));
    exec(`BFS_OP_BIT_TO_T, 1);
    `TB_CHK("bit to T", 8'h40, statusFlags)
    wbXfer(1'b1, `BFS_ADR_OPND, opnd(9, 0, 0));
    exec(`BFS_OP_T_TO_BIT, 1);
    wbXfer(1'b0, gA(9), 32'h0);
    `TB_CHK("T to bit set", 32'h41, rd)
    wbXfer(1'b1, `BFS_ADR_STATUS, 32'hBF);
    wbXfer(1'b1, `BFS_ADR_OPND, opnd(9, 6, 0));
    exec(`BFS_OP_T_TO_BIT, 1);
    wbXfer(1'b0, gA(9), 32'h0);
    `TB_CHK("T to bit clear", 32'h01, rd)
    `TB_CHK("T to bit flags", 8'hBF, statusFlags)
    $display("TEST transfer flag done");

    ops = '{`BFS_OP_NOP, `BFS_OP_SLEEP, `BFS_OP_WDR, `BFS_OP_BREAK, `BFS_OP_BREAK};
    wbXfer(1'b1, `BFS_ADR_STATUS, 32'hC3);
    foreach (ops[k])
    begin
      debugEnable <= (k == 4);
      exec(ops[k], 1);
      wbXfer(1'b0, `BFS_ADR_CMD, 32'h0);
      `TB_CHK("last opcode", {18'h0, ops[k], 8'h00}, rd)
      `TB_CHK("sleep pulses", int'(k >= 1), nSleep)
      `TB_CHK("restart pulses", int'(k >= 2), nWdr)
      `TB_CHK("break pulses", int'(k >= 4), nBrk)
      `TB_CHK("control flags", 8'hC3, statusFlags)
    end
    $display("TEST control done");
    wrapUp;
  end
endmodule // bfs_bit_flag_core_tb
